// ---- verilog/crs_defs.vh ----
// Constants for the CPU register set: widths, indices, system register numbers.
// Assumes inclusion by bare name from the design files only.
`ifndef CRS_DEFS_VH
`define CRS_DEFS_VH

`define CRS_XLEN 32
`define CRS_IDX_W 5
`define CRS_GPR_ZERO 5'h0_0
`define CRS_GPR_EP 5'h1_e
`define CRS_PC_VALID_W 26
`define CRS_PC_MASK 32'h03ff_fffe
`define CRS_SR_IRQ_PC 5'h0_0
`define CRS_SR_IRQ_ST 5'h0_1
`define CRS_SR_NMI_PC 5'h0_2
`define CRS_SR_NMI_ST 5'h0_3
`define CRS_SR_CAUSE 5'h0_4
`define CRS_SR_PSW 5'h0_5
`define CRS_SR_TC_PC 5'h1_0
`define CRS_SR_TC_ST 5'h1_1
`define CRS_SR_DBG_PC 5'h1_2
`define CRS_SR_DBG_ST 5'h1_3
`define CRS_SR_TC_BASE 5'h1_4
`define CRS_RST_WORD 32'h0000_0000

`endif

// ---- verilog/crs_gpr_mem.v ----
// General-purpose register storage: one write port, two registered read ports.
// Assumes the caller clears index zero during reset and discards later writes to it.
`timescale 1ns/1ps
`default_nettype none
`include "crs_defs.vh"

module crs_gpr_mem #(
  parameter WIDTH = 32,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  input wire i_mclk,
  input wire i_we,
  input wire [AW-1:0] i_waddr,
  input wire [WIDTH-1:0] i_wdata,
  input wire [AW-1:0] i_raddr_a,
  input wire [AW-1:0] i_raddr_b,
  output reg [WIDTH-1:0] o_rdata_a,
  output reg [WIDTH-1:0] o_rdata_b
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];

  always @(posedge i_mclk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata_a <= mem[i_raddr_a];
    o_rdata_b <= mem[i_raddr_b];
  end
endmodule // crs_gpr_mem
`default_nettype wire

// ---- verilog/crs_register_set.v ----
// CPU architectural register set: 32 GPRs, program counter, system registers.
// Assumes the decode/execute pipeline drives all requests synchronously to i_mclk.
`timescale 1ns/1ps
`default_nettype none
`include "crs_defs.vh"

// Operation
// [RULE1] Thirty-two general-purpose registers, index 0 to 31, hold data or addresses.
// [RULE2] Every register, general or system, is 32 bits wide.
// [RULE3] GPR index 0 always reads as zero. Here it reads unknown until the first reset clears it.
// [RULE4] Short loads and stores use GPR index 30 as base pointer.
// [RULE5] A separate program counter holds the executing instruction address.
// [RULE6] PC spans 64 MB program space; data addresses span 4 GB.
// [RULE7] Dedicated save pairs, cause, status word and table-call base exist.
// [RULE8] Only PC bits 25..1 live; bits 31..26 and 0 read zero.
// [RULE9] System registers selected by number; cause is read-only at 4.
// [RULE10] Writes to GPR index 0 are discarded.
module crs_register_set #(
  parameter XLEN = `CRS_XLEN
) (
  input wire i_mclk,
  input wire i_rst,
  input wire [`CRS_IDX_W-1:0] i_rd_idx_a,
  input wire [`CRS_IDX_W-1:0] i_rd_idx_b,
  input wire i_short_mem,
  input wire i_gpr_we,
  input wire [`CRS_IDX_W-1:0] i_gpr_widx,
  input wire [XLEN-1:0] i_gpr_wdata,
  input wire i_pc_we,
  input wire [XLEN-1:0] i_pc_wdata,
  input wire [`CRS_IDX_W-1:0] i_sr_idx,
  input wire i_sr_we,
  input wire [XLEN-1:0] i_sr_wdata,
  input wire i_cause_we,
  input wire [XLEN-1:0] i_cause_wdata,
  output wire [XLEN-1:0] o_rdata_a,
  output wire [XLEN-1:0] o_rdata_b,
  output reg [XLEN-1:0] o_pc,
  output reg [XLEN-1:0] o_sr_rdata,
  output reg o_sr_bad,
  output reg [XLEN-1:0] o_psw
);
  // ****************************************************************
  // General-purpose registers
  // ****************************************************************
  wire [`CRS_IDX_W-1:0] idx_a;
  wire gpr_we;
  wire mem_we;
  wire [`CRS_IDX_W-1:0] mem_waddr;
  wire [XLEN-1:0] mem_wdata;

  assign idx_a = i_short_mem ? `CRS_GPR_EP : i_rd_idx_a; // [RULE4]
  assign gpr_we = i_gpr_we && (i_gpr_widx != `CRS_GPR_ZERO); // [RULE10]

  // ****************************************************************
  // Index zero clearing
  // ****************************************************************
  // Index zero is cleared through the write port while reset is high, and every later
  // write to it is dropped, so it reads zero with no mux behind the memory.
  // That keeps both read ports straight from the memory's output registers.
  // A read of index zero before the first reset returns unknown data.
  assign mem_we = i_rst | gpr_we;
  assign mem_waddr = i_rst ? `CRS_GPR_ZERO : i_gpr_widx;
  assign mem_wdata = i_rst ? `CRS_RST_WORD : i_gpr_wdata; // [RULE3]

  // ****************************************************************
  // Storage
  // ****************************************************************
  crs_gpr_mem #(.WIDTH(XLEN), .DEPTH(32), .AW(`CRS_IDX_W)) u_mem ( // [RULE1]
    .i_mclk(i_mclk),
    .i_we(mem_we),
    .i_waddr(mem_waddr),
    .i_wdata(mem_wdata),
    .i_raddr_a(idx_a),
    .i_raddr_b(i_rd_idx_b),
    .o_rdata_a(o_rdata_a),
    .o_rdata_b(o_rdata_b)
  );

  // ****************************************************************
  // Program counter and system registers
  // ****************************************************************
  localparam NSLOT = 10;
  localparam [3:0] SLOT_IRQ_PC = 4'h0;
  localparam [3:0] SLOT_IRQ_ST = 4'h1;
  localparam [3:0] SLOT_NMI_PC = 4'h2;
  localparam [3:0] SLOT_NMI_ST = 4'h3;
  localparam [3:0] SLOT_CAUSE = 4'h4;
  localparam [3:0] SLOT_TC_PC = 4'h5;
  localparam [3:0] SLOT_TC_ST = 4'h6;
  localparam [3:0] SLOT_DBG_PC = 4'h7;
  localparam [3:0] SLOT_DBG_ST = 4'h8;
  localparam [3:0] SLOT_TC_BASE = 4'h9;
  localparam [3:0] SLOT_STATUS = 4'he;
  localparam [3:0] SLOT_NONE = 4'hf;

  wire [XLEN-1:0] sr_q [0:NSLOT-1]; // [RULE2]
  wire [NSLOT-1:0] slot_load;
  reg [XLEN-1:0] sr_rd_nxt;
  reg sr_bad_nxt;
  reg [3:0] rd_slot;

  // Numbers 0..4 sit in slots 0..4 and numbers 16..20 in slots 5..9. The status word
  // has no slot, because it is a port of its own and must not lag a slot copy.
  function [3:0] sr_slot;
    input [`CRS_IDX_W-1:0] num;
    begin
      case (num)
        `CRS_SR_IRQ_PC: sr_slot = SLOT_IRQ_PC;
        `CRS_SR_IRQ_ST: sr_slot = SLOT_IRQ_ST;
        `CRS_SR_NMI_PC: sr_slot = SLOT_NMI_PC;
        `CRS_SR_NMI_ST: sr_slot = SLOT_NMI_ST;
        `CRS_SR_CAUSE: sr_slot = SLOT_CAUSE;
        `CRS_SR_PSW: sr_slot = SLOT_STATUS;
        `CRS_SR_TC_PC: sr_slot = SLOT_TC_PC;
        `CRS_SR_TC_ST: sr_slot = SLOT_TC_ST;
        `CRS_SR_DBG_PC: sr_slot = SLOT_DBG_PC;
        `CRS_SR_DBG_ST: sr_slot = SLOT_DBG_ST;
        `CRS_SR_TC_BASE: sr_slot = SLOT_TC_BASE;
        default: sr_slot = SLOT_NONE;
      endcase
    end
  endfunction

  // The cause slot is left out: it takes only the hardware load.
  function sr_soft_load;
    input we;
    input [`CRS_IDX_W-1:0] num;
    input [3:0] slot;
    begin
      sr_soft_load = we && (sr_slot(num) == slot) && (slot != SLOT_CAUSE); // [RULE9]
    end
  endfunction

  // ****************************************************************
  // System register write decode
  // ****************************************************************
  // The debug pair is writable at any time here; restricting it to trap handling is
  // left to the pipeline, which knows when a trap is being serviced.
  genvar w;
  generate
    for (w = 0; w < NSLOT; w = w + 1) begin : g_load
      localparam [3:0] SLOT_ID = w;
      if (SLOT_ID == SLOT_CAUSE) begin : g_hw
        assign slot_load[w] = i_cause_we;
      end else begin : g_sw
        assign slot_load[w] = sr_soft_load(i_sr_we, i_sr_idx, SLOT_ID); // [RULE9]
      end
    end
  endgenerate

  // ****************************************************************
  // System register slots
  // ****************************************************************
  genvar j;
  generate
    for (j = 0; j < NSLOT; j = j + 1) begin : g_slot
      localparam [3:0] SLOT_ID = j;
      reg [XLEN-1:0] q_r;
      always @(posedge i_mclk) begin
        if (i_rst) begin
          q_r <= `CRS_RST_WORD; // [RULE7]
        end else if (slot_load[j]) begin
          q_r <= (SLOT_ID == SLOT_CAUSE) ? i_cause_wdata : i_sr_wdata;
        end
      end
      assign sr_q[j] = q_r;
    end
  endgenerate

  // ****************************************************************
  // System register read
  // ****************************************************************
  always @* begin
    rd_slot = sr_slot(i_sr_idx);
    sr_bad_nxt = (rd_slot == SLOT_NONE); // [RULE9]
    sr_rd_nxt = `CRS_RST_WORD;
    if (rd_slot == SLOT_STATUS) begin
      sr_rd_nxt = o_psw;
    end else if (rd_slot < NSLOT) begin
      sr_rd_nxt = sr_q[rd_slot];
    end
  end

  // ****************************************************************
  // Program counter
  // ****************************************************************
  // The mask drops bit 0 and every carry past the valid range in one place.
  always @(posedge i_mclk) begin
    if (i_rst) begin
      o_pc <= `CRS_RST_WORD;
    end else if (i_pc_we) begin
      o_pc <= i_pc_wdata & `CRS_PC_MASK; // [RULE5] [RULE6] [RULE8]
    end
  end

  // ****************************************************************
  // Status word and read-back registers
  // ****************************************************************
  // A reserved number reads zero and raises o_sr_bad; its writes are dropped.
  always @(posedge i_mclk) begin
    if (i_rst) begin
      o_psw <= `CRS_RST_WORD;
      o_sr_rdata <= `CRS_RST_WORD;
      o_sr_bad <= 1'b0;
    end else begin
      o_sr_rdata <= sr_rd_nxt;
      o_sr_bad <= sr_bad_nxt;
      if (sr_soft_load(i_sr_we, i_sr_idx, SLOT_STATUS)) begin
        o_psw <= i_sr_wdata; // [RULE9]
      end
    end
  end
endmodule // crs_register_set
`default_nettype wire

// ---- sim/crs_props.sv ----
// Port assertions for the CPU register set.
// Bound onto crs_register_set; one clock, synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module crs_props (
  input wire i_mclk, i_rst, i_short_mem, i_gpr_we, i_pc_we, i_sr_we, o_sr_bad,
  input wire [4:0] i_rd_idx_a, i_rd_idx_b, i_gpr_widx, i_sr_idx,
  input wire [31:0] i_pc_wdata, i_sr_wdata, o_rdata_a, o_rdata_b, o_pc, o_sr_rdata, o_psw
);
  wire rsv = i_sr_idx > 5'h1_4 || (i_sr_idx > 5'h0_5 && i_sr_idx < 5'h1_0);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  sequence s_w0;
    i_gpr_we && i_gpr_widx == 5'h0_0 ##1 i_rd_idx_b == 5'h0_0;
  endsequence
  property p_z; i_rd_idx_a == 5'h0_0 && !i_short_mem |=> !o_rdata_a; endproperty
  a_z: assert property (p_z) else $error("zero read");
  property p_w0; s_w0 |=> !o_rdata_b; endproperty
  a_w0: assert property (p_w0) else $error("zero kept write");
  property p_ep; i_short_mem && i_rd_idx_b == 5'h1_e |=> o_rdata_a == o_rdata_b; endproperty
  a_ep: assert property (p_ep) else $error("base index");
  property p_pm; !(o_pc & 32'hfc00_0001); endproperty
  a_pm: assert property (p_pm) else $error("pc bits");
  property p_pl; i_pc_we |=> o_pc == ($past(i_pc_wdata) & 32'h03ff_fffe); endproperty
  a_pl: assert property (p_pl) else $error("pc load");
  property p_rs; rsv |=> o_sr_bad && !o_sr_rdata; endproperty
  a_rs: assert property (p_rs) else $error("reserved number");
  property p_ok; !rsv |=> !o_sr_bad; endproperty
  a_ok: assert property (p_ok) else $error("mapped refused");
  property p_ps; i_sr_we && i_sr_idx == 5'h0_5 |=> o_psw == $past(i_sr_wdata); endproperty
  a_ps: assert property (p_ps) else $error("status load");
  property p_pr; i_sr_idx == 5'h0_5 && !i_sr_we |=> o_sr_rdata == o_psw; endproperty
  a_pr: assert property (p_pr) else $error("status read");
  sequence s_tw;
    i_sr_we && i_sr_idx == 5'h1_0 ##1 i_sr_idx == 5'h1_0 && !i_sr_we;
  endsequence
  property p_tw; s_tw |=> o_sr_rdata == $past(i_sr_wdata, 2); endproperty
  a_tw: assert property (p_tw) else $error("table call save read");
endmodule // crs_props
bind crs_register_set crs_props props_u (.*);
`default_nettype wire

// ---- sim/crs_pipe_model.sv ----
// Pipeline request model: sweeps every GPR index after reset, then random traffic.
// Assumes reset is high from time zero.
`timescale 1ns/1ps
`default_nettype none
module crs_pipe_model (
  input wire i_mclk, i_rst,
  output logic [4:0] i_rd_idx_a, i_rd_idx_b, i_gpr_widx, i_sr_idx,
  output logic i_short_mem, i_gpr_we, i_pc_we, i_sr_we, i_cause_we,
  output logic [31:0] i_gpr_wdata, i_pc_wdata, i_sr_wdata, i_cause_wdata
);
  int n;
  initial begin
    {i_rd_idx_a, i_rd_idx_b, i_gpr_widx, i_sr_idx} = 20'h0_0000;
    {i_short_mem, i_gpr_we, i_pc_we, i_sr_we, i_cause_we} = 5'h00;
    {i_gpr_wdata, i_pc_wdata, i_sr_wdata, i_cause_wdata} = 128'h0;
    void'($urandom(32'h93a9));
    n = 0;
    forever begin
      @(negedge i_mclk);
      n = i_rst ? 0 : n + 1;
      {i_gpr_wdata, i_sr_wdata, i_cause_wdata} <= {3{32'($urandom)}};
      i_pc_wdata <= n[2:0] == 3'h0 ? 32'hffff_ffff : 32'($urandom);
      // Unwritten registers read unknown, so the base index stays off until all are set.
      if (n > 0 && n < 33) begin
        {i_rd_idx_a, i_rd_idx_b, i_gpr_widx, i_sr_idx} <= {10'($urandom), n[4:0], 5'($urandom)};
        {i_short_mem, i_gpr_we, i_pc_we, i_sr_we, i_cause_we} <= {2'b01, 3'($urandom)};
      end else begin
        {i_rd_idx_a, i_rd_idx_b, i_gpr_widx, i_sr_idx} <= 20'($urandom);
        {i_short_mem, i_gpr_we, i_pc_we, i_sr_we, i_cause_we} <= i_rst ? 5'h00 : 5'($urandom);
      end
    end
  end
endmodule // crs_pipe_model
`default_nettype wire

// ---- sim/crs_register_set_tb.sv ----
// Self-checking bench for the CPU register set.
// Assumes crs_pipe_model drives every request.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin fail_count++; \
  $display("unexpected %0t output mismatch", $time); end end
module crs_register_set_tb;
  logic i_mclk;
  logic i_rst = 1'b1;
  wire [4:0] i_rd_idx_a, i_rd_idx_b, i_gpr_widx, i_sr_idx;
  wire i_short_mem, i_gpr_we, i_pc_we, i_sr_we, i_cause_we, o_sr_bad;
  wire [31:0] i_gpr_wdata, i_pc_wdata, i_sr_wdata, i_cause_wdata;
  wire [31:0] o_rdata_a, o_rdata_b, o_pc, o_sr_rdata, o_psw;
  logic [31:0] g [32], s [32], ea, eb, es, pc;
  logic kn [32], va, vb, vs, bad;
  logic [4:0] ra;
  int fail_count = 0, cmp_count = 0, cyc = 0;
  crs_register_set dut_u (.*);
  crs_pipe_model pm_u (.*);
  function automatic logic mapped(logic [4:0] n);
    return n < 5'h0_6 || (n > 5'h0_f && n < 5'h1_5);
  endfunction
  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    i_mclk = 1'b0;
    forever #50 i_mclk = ~i_mclk;
  end
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 6000) begin
      fail_count++;
      finish_test();
    end
    ra = i_short_mem ? 5'h1_e : i_rd_idx_a;
    va = kn[ra] && !(i_gpr_we && i_gpr_widx == ra);
    vb = kn[i_rd_idx_b] && !(i_gpr_we && i_gpr_widx == i_rd_idx_b);
    ea = g[ra];
    eb = g[i_rd_idx_b];
    bad = !mapped(i_sr_idx);
    es = bad ? 32'h0000_0000 : s[i_sr_idx];
    vs = !i_sr_we && !i_cause_we;
    if (i_rst) begin
      s = '{default: 32'h0000_0000};
      kn = '{default: 1'b0};
      pc = 32'h0000_0000;
    end else begin
      if (i_gpr_we) g[i_gpr_widx] = i_gpr_wdata;
      if (i_gpr_we) kn[i_gpr_widx] = 1'b1;
      if (i_pc_we) pc = i_pc_wdata & 32'h03ff_fffe;
      if (i_sr_we && !bad && i_sr_idx != 5'h0_4) s[i_sr_idx] = i_sr_wdata;
      if (i_cause_we) s[4] = i_cause_wdata;
    end
    g[0] = 32'h0000_0000;
    kn[0] = 1'b1;
  end
  always @(negedge i_mclk) if (!i_rst) begin
    if (va) `CHK(o_rdata_a, ea)
    if (vb) `CHK(o_rdata_b, eb)
    if (vs) `CHK(o_sr_rdata, es)
    `CHK(o_sr_bad, bad)
    `CHK(o_pc, pc)
    `CHK(o_psw, s[5])
  end
  initial begin
    repeat (6) @(negedge i_mclk);
    i_rst <= 1'b0;
    repeat (2000) @(negedge i_mclk);
    i_rst <= 1'b1;
    @(negedge i_mclk);
    i_rst <= 1'b0;
    repeat (2000) @(negedge i_mclk);
    finish_test();
  end
endmodule // crs_register_set_tb
`default_nettype wire
